//--- inc/twom_pkg.sv
// Package: constants and types for the 16-bit timer waveform output block
package twom_pkg;

   // ==========================================
   // Widths, channel count and channel index
   localparam int CNT_W = 16;
   localparam int NUM_CH = 3;
   localparam int CH_A = 0;

   // ==========================================
   // Fixed counter values
   localparam logic [15:0] BOTTOM_VAL = 16'h0000;
   localparam logic [15:0] MAX_VAL = 16'hFFFF;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;

   // ==========================================
   // Waveform mode codes
   localparam logic [3:0] WM_NORMAL = 4'h0;
   localparam logic [3:0] WM_PC8 = 4'h1;
   localparam logic [3:0] WM_PC9 = 4'h2;
   localparam logic [3:0] WM_PC10 = 4'h3;
   localparam logic [3:0] WM_CTC_A = 4'h4;
   localparam logic [3:0] WM_FP8 = 4'h5;
   localparam logic [3:0] WM_FP9 = 4'h6;
   localparam logic [3:0] WM_FP10 = 4'h7;
   localparam logic [3:0] WM_PFC_CAP = 4'h8;
   localparam logic [3:0] WM_PFC_A = 4'h9;
   localparam logic [3:0] WM_PC_CAP = 4'hA;
   localparam logic [3:0] WM_PC_A = 4'hB;
   localparam logic [3:0] WM_CTC_CAP = 4'hC;
   localparam logic [3:0] WM_RSVD = 4'hD;
   localparam logic [3:0] WM_FP_CAP = 4'hE;
   localparam logic [3:0] WM_FP_A = 4'hF;

   // ==========================================
   // Output action codes
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   // Reset values
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic OUT_RST = 1'b0;

   // ==========================================
   // Types
   typedef enum logic [1:0] {
      TWOM_KIND_NONPWM,
      TWOM_KIND_FAST,
      TWOM_KIND_DUAL
   } twom_kind_t;

   typedef enum logic [1:0] {
      TWOM_TOP_FIXED,
      TWOM_TOP_CMPA,
      TWOM_TOP_CAP
   } twom_top_src_t;

   typedef enum logic [1:0] {
      TWOM_UPD_NOW,
      TWOM_UPD_TOP,
      TWOM_UPD_BOTTOM
   } twom_upd_t;

   typedef enum logic [1:0] {
      TWOM_OVF_MAX,
      TWOM_OVF_TOP,
      TWOM_OVF_BOTTOM
   } twom_ovf_t;

   // Decoded mode attributes
   typedef struct packed {
      twom_kind_t kind;
      twom_top_src_t top_src;
      logic [15:0] fixed_top;
      twom_upd_t upd;
      twom_ovf_t ovf;
      logic reserved;
   } twom_mode_t;

   // Per-channel compare setup
   typedef struct packed {
      logic [1:0] action;
      logic [15:0] compare;
   } twom_chan_cfg_t;

endpackage

//--- hdl/twom_mode_dec.sv
// Waveform mode decoder: counting sequence, TOP source, update and flag points
module twom_mode_dec (
   input wire logic [3:0] waveform_mode_select,
   output twom_pkg::twom_mode_t mode
);

   // ==========================================
   // Decode table
   always_comb begin
      mode.kind = twom_pkg::TWOM_KIND_NONPWM;
      mode.top_src = twom_pkg::TWOM_TOP_FIXED;
      mode.fixed_top = twom_pkg::MAX_VAL;
      mode.upd = twom_pkg::TWOM_UPD_NOW;
      mode.ovf = twom_pkg::TWOM_OVF_MAX;
      mode.reserved = 1'b0;
      case (waveform_mode_select)
         twom_pkg::WM_NORMAL: begin
            mode.fixed_top = twom_pkg::MAX_VAL;
         end
         twom_pkg::WM_CTC_A: begin
            mode.top_src = twom_pkg::TWOM_TOP_CMPA;
         end
         twom_pkg::WM_CTC_CAP: begin
            mode.top_src = twom_pkg::TWOM_TOP_CAP;
         end
         twom_pkg::WM_PC8, twom_pkg::WM_PC9, twom_pkg::WM_PC10: begin
            mode.kind = twom_pkg::TWOM_KIND_DUAL;
            mode.upd = twom_pkg::TWOM_UPD_TOP;
            mode.ovf = twom_pkg::TWOM_OVF_BOTTOM;
            if (waveform_mode_select == twom_pkg::WM_PC8) begin
               mode.fixed_top = twom_pkg::TOP_8BIT;
            end else if (waveform_mode_select == twom_pkg::WM_PC9) begin
               mode.fixed_top = twom_pkg::TOP_9BIT;
            end else begin
               mode.fixed_top = twom_pkg::TOP_10BIT;
            end
         end
         twom_pkg::WM_PC_CAP, twom_pkg::WM_PC_A: begin
            mode.kind = twom_pkg::TWOM_KIND_DUAL;
            mode.upd = twom_pkg::TWOM_UPD_TOP;
            mode.ovf = twom_pkg::TWOM_OVF_BOTTOM;
            mode.top_src = (waveform_mode_select == twom_pkg::WM_PC_A) ?
               twom_pkg::TWOM_TOP_CMPA : twom_pkg::TWOM_TOP_CAP;
         end
         twom_pkg::WM_PFC_CAP, twom_pkg::WM_PFC_A: begin
            mode.kind = twom_pkg::TWOM_KIND_DUAL;
            mode.upd = twom_pkg::TWOM_UPD_BOTTOM;
            mode.ovf = twom_pkg::TWOM_OVF_BOTTOM;
            mode.top_src = (waveform_mode_select == twom_pkg::WM_PFC_A) ?
               twom_pkg::TWOM_TOP_CMPA : twom_pkg::TWOM_TOP_CAP;
         end
         twom_pkg::WM_FP8, twom_pkg::WM_FP9, twom_pkg::WM_FP10: begin
            mode.kind = twom_pkg::TWOM_KIND_FAST;
            mode.upd = twom_pkg::TWOM_UPD_BOTTOM;
            mode.ovf = twom_pkg::TWOM_OVF_TOP;
            if (waveform_mode_select == twom_pkg::WM_FP8) begin
               mode.fixed_top = twom_pkg::TOP_8BIT;
            end else if (waveform_mode_select == twom_pkg::WM_FP9) begin
               mode.fixed_top = twom_pkg::TOP_9BIT;
            end else begin
               mode.fixed_top = twom_pkg::TOP_10BIT;
            end
         end
         twom_pkg::WM_FP_CAP, twom_pkg::WM_FP_A: begin
            mode.kind = twom_pkg::TWOM_KIND_FAST;
            mode.upd = twom_pkg::TWOM_UPD_BOTTOM;
            mode.ovf = twom_pkg::TWOM_OVF_TOP;
            mode.top_src = (waveform_mode_select == twom_pkg::WM_FP_A) ?
               twom_pkg::TWOM_TOP_CMPA : twom_pkg::TWOM_TOP_CAP;
         end
         default: begin
            mode.reserved = 1'b1;
         end
      endcase
   end

endmodule

//--- hdl/twom_timer.sv
// 16-bit timer with mode decode, three compare channels and waveform outputs
module twom_timer (
   input wire logic clk,
   input wire logic nrst,
   input wire logic timer_tick,
   input wire logic [3:0] waveform_mode_select,
   input wire twom_pkg::twom_chan_cfg_t [2:0] chan_cfg,
   input wire logic [15:0] capture_top_value,
   input wire logic [2:0] force_match_strobe,
   input wire logic counter_write,
   input wire logic [15:0] counter_write_value,
   input wire logic overflow_ack,
   input wire logic [2:0] match_ack,
   input wire logic [2:0] port_data,
   input wire logic [2:0] port_dir,
   output logic [15:0] counter_value,
   output logic count_down,
   output logic overflow_flag,
   output logic [2:0] channel_match_flag,
   output logic [2:0] channel_output_state,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe
);

   // ==========================================
   // Mode decode
   twom_pkg::twom_mode_t mode;

   twom_mode_dec u_dec (
      .waveform_mode_select(waveform_mode_select),
      .mode(mode)
   );

   // Channel output connected to the pin for a given mode
   function automatic logic chan_connected(input logic [1:0] act, input logic [3:0] wm,
                                           input twom_pkg::twom_kind_t kind, input int ch);
      logic r;
      r = (act != twom_pkg::ACT_OFF);
      if (act == twom_pkg::ACT_TOGGLE) begin
         if (kind == twom_pkg::TWOM_KIND_FAST) begin
            r = (ch == twom_pkg::CH_A) &&
                (wm == twom_pkg::WM_FP_CAP || wm == twom_pkg::WM_FP_A);
         end else if (kind == twom_pkg::TWOM_KIND_DUAL) begin
            r = (ch == twom_pkg::CH_A) &&
                (wm == twom_pkg::WM_PFC_A || wm == twom_pkg::WM_PC_A);
         end
      end
      return r;
   endfunction

   // Output state after a match
   function automatic logic match_result(input logic [1:0] act, input logic cur,
                                         input twom_pkg::twom_kind_t kind, input logic down);
      logic r;
      r = cur;
      case (act)
         twom_pkg::ACT_TOGGLE: r = ~cur;
         twom_pkg::ACT_CLEAR: r = (kind == twom_pkg::TWOM_KIND_DUAL) ? down : 1'b0;
         twom_pkg::ACT_SET: r = (kind == twom_pkg::TWOM_KIND_DUAL) ? ~down : 1'b1;
         default: r = cur;
      endcase
      return r;
   endfunction

   // ==========================================
   // Counter and double-buffered compare values
   logic [15:0] cnt_q, cnt_d;
   logic down_q, down_d;
   logic [2:0][15:0] cmp_q, cmp_d;
   logic blk_q, blk_d;
   logic [15:0] top;
   logic at_top, at_bottom, wrap;

   always_comb begin
      if (mode.top_src == twom_pkg::TWOM_TOP_CMPA) begin
         top = cmp_q[twom_pkg::CH_A];
      end else if (mode.top_src == twom_pkg::TWOM_TOP_CAP) begin
         top = capture_top_value;
      end else begin
         top = mode.fixed_top;
      end
      at_top = (cnt_q == top);
      at_bottom = (cnt_q == twom_pkg::BOTTOM_VAL);
      wrap = 1'b0;
      cnt_d = cnt_q;
      down_d = down_q;
      blk_d = counter_write ? 1'b1 : (timer_tick ? 1'b0 : blk_q);
      cmp_d = cmp_q;
      if (counter_write) begin
         cnt_d = counter_write_value;
      end else if (timer_tick && !mode.reserved) begin
         case (mode.kind)
            twom_pkg::TWOM_KIND_DUAL: begin
               if (!down_q && at_top && !at_bottom) begin
                  down_d = 1'b1;
                  cnt_d = cnt_q - 16'h0001;
               end else if (down_q && (at_bottom || cnt_q == 16'h0001)) begin
                  down_d = 1'b0;
                  cnt_d = cnt_q - 16'h0001;
                  if (at_bottom) begin
                     cnt_d = cnt_q + 16'h0001;
                  end
               end else begin
                  cnt_d = down_q ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
               end
            end
            twom_pkg::TWOM_KIND_FAST: begin
               cnt_d = at_top ? twom_pkg::BOTTOM_VAL : cnt_q + 16'h0001;
               wrap = at_top;
            end
            default: begin
               if (waveform_mode_select != twom_pkg::WM_NORMAL && at_top) begin
                  cnt_d = twom_pkg::BOTTOM_VAL;
               end else begin
                  cnt_d = cnt_q + 16'h0001;
               end
            end
         endcase
      end
      // Compare value loading
      for (int i = 0; i < twom_pkg::NUM_CH; i++) begin
         if (mode.upd == twom_pkg::TWOM_UPD_NOW) begin
            cmp_d[i] = chan_cfg[i].compare;
         end else if (timer_tick && mode.upd == twom_pkg::TWOM_UPD_TOP && at_top) begin
            cmp_d[i] = chan_cfg[i].compare;
         end else if (timer_tick && mode.upd == twom_pkg::TWOM_UPD_BOTTOM &&
                      (wrap || (mode.kind == twom_pkg::TWOM_KIND_DUAL && at_bottom))) begin
            cmp_d[i] = chan_cfg[i].compare;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= twom_pkg::CNT_RST;
         down_q <= 1'b0;
         cmp_q <= '0;
         blk_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         down_q <= down_d;
         cmp_q <= cmp_d;
         blk_q <= blk_d;
      end
   end

   // ==========================================
   // Flags and channel outputs
   logic ovf_q, ovf_d;
   logic [2:0] mflag_q, mflag_d;
   logic [2:0] oc_q, oc_d;
   logic [2:0] pout_q, pout_d;
   logic [2:0] poe_q, poe_d;
   logic ovf_evt;
   logic [2:0] hit;
   logic conn;

   always_comb begin
      ovf_evt = 1'b0;
      if (timer_tick && !counter_write && !mode.reserved) begin
         case (mode.ovf)
            twom_pkg::TWOM_OVF_MAX: ovf_evt = (cnt_q == twom_pkg::MAX_VAL);
            twom_pkg::TWOM_OVF_TOP: ovf_evt = at_top;
            default: ovf_evt = down_q && (cnt_q == 16'h0001 || at_bottom);
         endcase
      end
      ovf_d = ovf_evt ? 1'b1 : (overflow_ack ? 1'b0 : ovf_q);
      mflag_d = mflag_q;
      oc_d = oc_q;
      pout_d = pout_q;
      poe_d = poe_q;
      for (int i = 0; i < twom_pkg::NUM_CH; i++) begin
         // Match seen on the tick, flag registered for the next cycle
         hit[i] = timer_tick && !blk_q && !counter_write && !mode.reserved &&
                  (cnt_q == cmp_q[i]);
         mflag_d[i] = hit[i] ? 1'b1 : (match_ack[i] ? 1'b0 : mflag_q[i]);
         conn = chan_connected(chan_cfg[i].action, waveform_mode_select, mode.kind, i);
         if (mode.kind == twom_pkg::TWOM_KIND_NONPWM) begin
            if (hit[i] || (force_match_strobe[i] && !mode.reserved)) begin
               oc_d[i] = match_result(chan_cfg[i].action, oc_q[i], mode.kind,
                                      down_q);
            end
         end else if (conn && !mode.reserved) begin
            if (mode.kind == twom_pkg::TWOM_KIND_FAST) begin
               if (chan_cfg[i].action[1]) begin
                  if (wrap) begin
                     oc_d[i] = ~chan_cfg[i].action[0];
                  end else if (hit[i] && !at_top) begin
                     oc_d[i] = chan_cfg[i].action[0];
                  end
               end else if (hit[i]) begin
                  oc_d[i] = ~oc_q[i];
               end
            end else if (hit[i]) begin
               oc_d[i] = match_result(chan_cfg[i].action, oc_q[i], mode.kind, down_q);
            end
         end
         pout_d[i] = conn ? oc_d[i] : port_data[i];
         poe_d[i] = port_dir[i];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ovf_q <= 1'b0;
         mflag_q <= '0;
         oc_q <= {twom_pkg::NUM_CH{twom_pkg::OUT_RST}};
         pout_q <= '0;
         poe_q <= '0;
      end else begin
         ovf_q <= ovf_d;
         mflag_q <= mflag_d;
         oc_q <= oc_d;
         pout_q <= pout_d;
         poe_q <= poe_d;
      end
   end

   // ==========================================
   // Outputs
   assign counter_value = cnt_q;
   assign count_down = down_q;
   assign overflow_flag = ovf_q;
   assign channel_match_flag = mflag_q;
   assign channel_output_state = oc_q;
   assign pin_out = pout_q;
   assign pin_oe = poe_q;

endmodule

//--- verif/twom_pin_load.sv
// Pin load model: pads driven from the block's pins, pulled high when released
module twom_pin_load (
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe,
   output logic [2:0] pad_level
);
   timeunit 1ns;
   timeprecision 100ps;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         // Released pin floats to the pull-up
         pad_level[i] = pin_oe[i] ? pin_out[i] : 1'b1;
      end
   end
endmodule

//--- verif/twom_timer_chk.sv
// Checker: port-level properties of the timer waveform block
module twom_timer_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic timer_tick,
   input wire logic [3:0] waveform_mode_select,
   input wire twom_pkg::twom_chan_cfg_t [2:0] chan_cfg,
   input wire logic [2:0] force_match_strobe,
   input wire logic counter_write,
   input wire logic overflow_ack,
   input wire logic [2:0] match_ack,
   input wire logic [2:0] port_data,
   input wire logic [2:0] port_dir,
   input wire logic [15:0] counter_value,
   input wire logic count_down,
   input wire logic overflow_flag,
   input wire logic [2:0] channel_match_flag,
   input wire logic [2:0] channel_output_state,
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic blk_q;
   logic blk_d;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Match blocked through the first tick after a counter write
   always_comb begin
      blk_d = counter_write | (blk_q & ~timer_tick);
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         blk_q <= 1'b0;
      end else begin
         blk_q <= blk_d;
      end
   end
   // ==========================================
   // Assertions
   a_wrap_overflow:
   assert property (waveform_mode_select == 4'h0 && timer_tick && !counter_write
      && counter_value == 16'hFFFF |=> counter_value == 16'h0000 && overflow_flag)
      else $error("no wrap with overflow");
   a_ovf_ack:
   assert property (overflow_ack && !timer_tick |=> !overflow_flag)
      else $error("overflow not cleared by ack");
   a_match_flag:
   assert property (waveform_mode_select == 4'h0 && timer_tick && !counter_write && !blk_q
      && $stable(chan_cfg[0].compare) && counter_value == chan_cfg[0].compare
      |=> channel_match_flag[0])
      else $error("match flag missing");
   a_zero_hold:
   assert property (chan_cfg[1].action == 2'h0 && $stable(chan_cfg[1].action)
      && !force_match_strobe[1] |=> $stable(channel_output_state[1]))
      else $error("state moved with action zero");
   a_force_set:
   assert property (waveform_mode_select == 4'h0 && force_match_strobe[1] && !timer_tick
      && !counter_write && !match_ack[1] && chan_cfg[1].action == 2'h3
      |=> channel_output_state[1] && $stable(channel_match_flag[1]) && $stable(counter_value))
      else $error("forced match wrong");
   a_pwm_force:
   assert property (waveform_mode_select == 4'h5 && force_match_strobe[1] && !timer_tick
      |=> $stable(channel_output_state))
      else $error("force acted in fast pwm");
   a_pin_conn:
   assert property (chan_cfg[1].action[1]
      |=> pin_out[1] == channel_output_state[1] && pin_oe == $past(port_dir))
      else $error("pin not driven by waveform");
   a_pin_port:
   assert property (chan_cfg[1].action == 2'h0 |=> pin_out[1] == $past(port_data[1]))
      else $error("pin not driven by port data");
   a_fast_bottom:
   assert property (waveform_mode_select == 4'h5 && timer_tick && !counter_write
      && counter_value == 16'h00FF && chan_cfg[2].action == 2'h3
      |=> counter_value == 16'h0000 && !channel_output_state[2] && overflow_flag)
      else $error("fast pwm bottom wrong");
   a_dual_turn:
   assert property (waveform_mode_select == 4'h1 && timer_tick && !counter_write
      && counter_value == 16'h00FF && !count_down |=> count_down && counter_value == 16'h00FE)
      else $error("no turn at top");
endmodule

bind twom_timer twom_timer_chk u_twom_timer_chk (
   .clk(clk), .nrst(nrst), .timer_tick(timer_tick), .waveform_mode_select(waveform_mode_select),
   .chan_cfg(chan_cfg), .force_match_strobe(force_match_strobe), .counter_write(counter_write),
   .overflow_ack(overflow_ack), .match_ack(match_ack), .port_data(port_data),
   .port_dir(port_dir), .counter_value(counter_value), .count_down(count_down),
   .overflow_flag(overflow_flag), .channel_match_flag(channel_match_flag),
   .channel_output_state(channel_output_state), .pin_out(pin_out), .pin_oe(pin_oe)
);

//--- verif/testbench.sv
// Testbench: directed sequences for the timer waveform block
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic timer_tick = 1'b0;
   logic [3:0] waveform_mode_select = 4'h0;
   twom_pkg::twom_chan_cfg_t [2:0] chan_cfg = '0;
   logic [2:0] force_match_strobe = 3'h0;
   logic counter_write = 1'b0;
   logic [15:0] counter_write_value = 16'h0000;
   logic overflow_ack = 1'b0;
   logic [2:0] match_ack = 3'h0;
   logic [15:0] capture_top_value = 16'h0000;
   logic [2:0] port_dir = 3'h3;
   logic [15:0] counter_value;
   logic count_down;
   logic overflow_flag;
   logic [2:0] channel_match_flag;
   logic [2:0] channel_output_state;
   logic [2:0] pin_out;
   logic [2:0] pin_oe;
   logic [2:0] pad_level;
   logic [1:0] acts [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
   logic e;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;

   twom_timer u_twom_timer (
      .clk(clk), .nrst(nrst), .timer_tick(timer_tick),
      .waveform_mode_select(waveform_mode_select), .chan_cfg(chan_cfg),
      .capture_top_value(capture_top_value), .force_match_strobe(force_match_strobe),
      .counter_write(counter_write), .counter_write_value(counter_write_value),
      .overflow_ack(overflow_ack), .match_ack(match_ack), .port_data(3'h7), .port_dir(port_dir),
      .counter_value(counter_value), .count_down(count_down), .overflow_flag(overflow_flag),
      .channel_match_flag(channel_match_flag), .channel_output_state(channel_output_state),
      .pin_out(pin_out), .pin_oe(pin_oe)
   );
   twom_pin_load u_twom_pin_load (.pin_out(pin_out), .pin_oe(pin_oe), .pad_level(pad_level));

   initial begin
      forever #20 clk = ~clk;
   end

   // ==========================================
   // Access tasks
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic run(input int n);
      @(posedge clk);
      timer_tick <= 1'b1;
      repeat (n) @(posedge clk);
      timer_tick <= 1'b0;
      @(negedge clk);
   endtask
   task automatic wr(input logic [15:0] v);
      @(posedge clk);
      counter_write <= 1'b1;
      counter_write_value <= v;
      @(posedge clk);
      counter_write <= 1'b0;
   endtask
   task automatic strobe(input logic [2:0] f, input logic oa, input logic [2:0] ma);
      @(posedge clk);
      force_match_strobe <= f;
      overflow_ack <= oa;
      match_ack <= ma;
      @(posedge clk);
      force_match_strobe <= 3'h0;
      overflow_ack <= 1'b0;
      match_ack <= 3'h0;
      @(negedge clk);
   endtask
   task automatic cfg(input int ch, input logic [1:0] a, input logic [15:0] c);
      @(posedge clk);
      chan_cfg[ch] <= '{action: a, compare: c};
   endtask
   task automatic set_mode(input logic [3:0] m);
      @(posedge clk);
      waveform_mode_select <= m;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         print_verdict();
      end
   end

   // ==========================================
   // Sequences
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      chk("counter", 16'h0000, counter_value);
      chk("state", 16'h0000, 16'(channel_output_state));
      wr(16'hFFFE);
      run(2);
      chk("counter", 16'h0000, counter_value);
      chk("overflow", 16'h0001, 16'(overflow_flag));
      strobe(3'h0, 1'b1, 3'h0);
      chk("overflow", 16'h0000, 16'(overflow_flag));
      cfg(0, 2'h1, 16'h0005);
      cfg(1, 2'h0, 16'h0005);
      cfg(2, 2'h3, 16'h0005);
      wr(16'h0003);
      run(3);
      chk("state", 16'h0005, 16'(channel_output_state));
      chk("match", 16'h0007, 16'(channel_match_flag));
      e = 1'b1;
      foreach (acts[i]) begin
         cfg(0, acts[i], 16'h0005);
         wr(16'h0004);
         run(2);
         e = (acts[i] == 2'h1) ? !e : ((acts[i] == 2'h0) ? e : acts[i][0]);
         chk("state_a", 16'(e), 16'(channel_output_state[0]));
      end
      @(negedge clk);
      chk("pads", 16'h0006, 16'(pad_level));
      strobe(3'h0, 1'b0, 3'h7);
      cfg(1, 2'h3, 16'h0005);
      strobe(3'h2, 1'b0, 3'h0);
      chk("state_b", 16'h0001, 16'(channel_output_state[1]));
      chk("match_b", 16'h0000, 16'(channel_match_flag[1]));
      chk("counter", 16'h0006, counter_value);
      set_mode(4'h5);
      cfg(1, 2'h2, 16'h0010);
      strobe(3'h2, 1'b0, 3'h0);
      chk("state_b", 16'h0001, 16'(channel_output_state[1]));
      cfg(2, 2'h3, 16'h0010);
      cfg(0, 2'h0, 16'h0010);
      wr(16'h00FE);
      run(2);
      chk("state", 16'h0002, 16'(channel_output_state));
      chk("overflow", 16'h0001, 16'(overflow_flag));
      run(17);
      chk("state", 16'h0004, 16'(channel_output_state));
      set_mode(4'h1);
      cfg(1, 2'h2, 16'h00FC);
      wr(16'h00FD);
      run(3);
      chk("counter", 16'h00FE, counter_value);
      chk("down", 16'h0001, 16'(count_down));
      run(3);
      chk("state_b", 16'h0001, 16'(channel_output_state[1]));
      set_mode(4'hD);
      cfg(0, 2'h1, 16'h0003);
      cfg(1, 2'h1, 16'h00FB);
      run(3);
      chk("counter", 16'h00FB, counter_value);
      chk("state", 16'h0006, 16'(channel_output_state));
      cfg(1, 2'h1, 16'h0003);
      set_mode(4'hF);
      wr(16'h0000);
      run(4);
      chk("state", 16'h0003, 16'(channel_output_state));
      set_mode(4'h9);
      run(4);
      chk("state", 16'h0002, 16'(channel_output_state));
      chk("down", 16'h0001, 16'(count_down));
      cfg(1, 2'h3, 16'h0001);
      strobe(3'h0, 1'b1, 3'h0);
      run(2);
      chk("overflow", 16'h0001, 16'(overflow_flag));
      chk("state_b", 16'h0001, 16'(channel_output_state[1]));
      set_mode(4'hC);
      capture_top_value <= 16'h0002;
      wr(16'h0000);
      run(4);
      chk("counter", 16'h0001, counter_value);
      @(posedge clk);
      port_dir <= 3'h4;
      repeat (2) @(negedge clk);
      chk("pads", 16'h0003, 16'(pad_level));
      print_verdict();
   end
endmodule
